// ### src/irpd_defines.svh
`ifndef IRPD_DEFINES_SVH
`define IRPD_DEFINES_SVH

// clock and resonator rates, in hertz
`define IRPD_CLK_HZ            125000000
`define IRPD_OSC_HZ            455000
// system clocks per resonator period, rounded to nearest
`define IRPD_OSC_DIV           ((`IRPD_CLK_HZ + (`IRPD_OSC_HZ / 2)) / `IRPD_OSC_HZ)

// carrier shape in resonator periods, pulse length in carrier periods
`define IRPD_CARRIER_OSC       12
`define IRPD_CARRIER_HIGH_OSC  4
`define IRPD_PULSE_PERIODS     6

// pulse spacing, in resonator periods and basic units
`define IRPD_BASIC_UNIT_OSC    1152
`define IRPD_REF_UNITS         3
`define IRPD_ZERO_UNITS        2
`define IRPD_ONE_UNITS         3
`define IRPD_WORD_SHORT_OSC    55296
`define IRPD_WORD_LONG_OSC     59904

// key matrix scan
`define IRPD_LINES             7
`define IRPD_SCAN_SLOT_OSC     4

// register byte offsets
`define IRPD_REG_CTRL          8'h00
`define IRPD_REG_STATUS        8'h04
`define IRPD_REG_WORDS         8'h08

// control fields and reset value
`define IRPD_CTRL_ENABLE_BIT   0
`define IRPD_CTRL_RESET        1'b1

// status fields
`define IRPD_STAT_ACTIVE_BIT   0
`define IRPD_STAT_MODE2_BIT    1
`define IRPD_STAT_TOGGLE_BIT   2
`define IRPD_STAT_HELD_BIT     3
`define IRPD_STAT_ADDR_LSB     4
`define IRPD_STAT_CMD_LSB      16

// words register fields
`define IRPD_WORDS_CNT_LSB     0
`define IRPD_WORDS_DRV_LSB     16

`endif

// ### src/irpd_pkg.sv
package irpd_pkg;

   // transmitter sequencing states
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_SCAN    = 2'b01,
      ST_SEND    = 2'b10
   } irpd_state_type;

   // classic wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } irpd_wb_req_type;

   // classic wishbone answer from the slave
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } irpd_wb_rsp_type;

endpackage : irpd_pkg

// ### src/irpd_osc_tick.sv
`timescale 1ns/1ps
`include "irpd_defines.svh"

// divides the system clock down to one pulse per resonator period
module irpd_osc_tick #(
   parameter int DIV = `IRPD_OSC_DIV
) (
   input  wire logic clk,     // system clock
   input  wire logic rst_b,   // async reset, active low
   output logic      oscTick  // one-cycle pulse per resonator period
);

   localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

   logic [W-1:0] divCnt_ff;
   logic         tick_ff;
   wire          divLast = (divCnt_ff == W'(DIV - 1));

   // free-running divider; the tick is registered so it is glitch free
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divCnt_ff <= '0;
         tick_ff   <= 1'b0;
      end else begin
         divCnt_ff <= divLast ? '0 : divCnt_ff + 1'b1;
         tick_ff   <= divLast;
      end
   end

   assign oscTick = tick_ff;

endmodule : irpd_osc_tick

// ### src/irpd_encoder.sv
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "irpd_defines.svh"

module irpd_encoder #(
   parameter int OSC_DIV = `IRPD_OSC_DIV,   // system clocks per resonator period
   parameter int LINES   = `IRPD_LINES      // matrix drive and sense lines
) (
   input  wire logic                     clk,                   // 125 MHz
   input  wire logic                     rst_b,                 // async, active low
   input  wire irpd_pkg::irpd_wb_req_type wbReq,                // wishbone request
   output irpd_pkg::irpd_wb_rsp_type     wbRsp,                 // wishbone answer
   input  wire logic [LINES-1:0]         keyDriveLinesIn,       // drive pin levels
   output logic      [LINES-1:0]         keyDriveLinesOut,      // drive level, always low
   output logic      [LINES-1:0]         keyDriveLinesOe,       // high: line pulled low
   input  wire logic [LINES-1:0]         keySenseLines,         // sense pins, low on key
   input  wire logic                     addressModeStrapInput, // strap pin level
   output logic                          strapPullUpEn,         // strap pull-up on
   output logic                          strapPullDnEn,         // strap pull-down on
   output logic                          infraredCodeOutput     // modulated code, high active
);

   localparam int SCAN_LEN = LINES * `IRPD_SCAN_SLOT_OSC;
   localparam logic [11:0] GAP_REF  = 12'(`IRPD_REF_UNITS * `IRPD_BASIC_UNIT_OSC - 1);
   localparam logic [11:0] GAP_ZERO = 12'(`IRPD_ZERO_UNITS * `IRPD_BASIC_UNIT_OSC - 1);
   localparam logic [11:0] GAP_ONE  = 12'(`IRPD_ONE_UNITS * `IRPD_BASIC_UNIT_OSC - 1);
   localparam logic [11:0] GAP_MID  = 12'((`IRPD_BASIC_UNIT_OSC * 3) / 2 - 1);
   localparam logic [15:0] SCAN_AT_SHORT = 16'(`IRPD_WORD_SHORT_OSC - SCAN_LEN - 1);
   localparam logic [15:0] SCAN_AT_LONG  = 16'(`IRPD_WORD_LONG_OSC - SCAN_LEN - 1);
   localparam logic [3:0]  CAR_LAST  = 4'(`IRPD_CARRIER_OSC - 1);
   localparam logic [3:0]  CAR_HIGH  = 4'(`IRPD_CARRIER_HIGH_OSC);
   localparam logic [2:0]  PER_LAST  = 3'(`IRPD_PULSE_PERIODS - 1);
   localparam logic [1:0]  SLOT_LAST = 2'(`IRPD_SCAN_SLOT_OSC - 1);
   localparam logic [2:0]  LINE_LAST = 3'(LINES - 1);

   // double sense contacts
   // lowest sense line pulled low; lines 5 and 6 together give 7
   function automatic logic [2:0] senseIndex(input logic [LINES-1:0] low);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = LINES - 1; i >= 0; i--) begin
         if (low[i]) begin
            idx = 3'(i);
         end
      end
      if (low[5] && low[6]) begin
         idx = 3'h7;
      end
      return idx;
   endfunction : senseIndex

   // strap pattern decode
   // strap mask of lines 0..5 to {long, subsystem_address_bits}
   function automatic logic [4:0] decodeStrap(input logic [5:0] m);
      logic [4:0] code;
      code = 5'h07;
      case (m)
         6'h01: code = 5'h00;
         6'h02: code = 5'h01;
         6'h04: code = 5'h02;
         6'h08: code = 5'h03;
         6'h10: code = 5'h04;
         6'h20: code = 5'h05;
         6'h05: code = 5'h10;
         6'h09: code = 5'h18;
         6'h11: code = 5'h14;
         6'h21: code = 5'h1c;
         6'h06: code = 5'h11;
         6'h0a: code = 5'h19;
         6'h12: code = 5'h15;
         6'h22: code = 5'h1d;
         6'h0c: code = 5'h1a;
         6'h14: code = 5'h16;
         6'h24: code = 5'h1e;
         6'h18: code = 5'h17;
         6'h28: code = 5'h1f;
         default: code = 5'h07;
      endcase
      return code;
   endfunction : decodeStrap

   logic                     oscTick;
   irpd_pkg::irpd_state_type state_ff, nxtState;
   logic [2*LINES:0]         syncA_ff, syncB_ff;
   logic [2:0]               scanLine_ff, nxtScanLine;
   logic [1:0]               slot_ff, nxtSlot;
   logic                     firstScan_ff, nxtFirstScan;
   logic [LINES-1:0]         strapMask_ff, nxtStrapMask;
   logic                     scanFound_ff, nxtScanFound;
   logic [5:0]               scanCode_ff, nxtScanCode;
   logic [5:0]               lastCode_ff, nxtLastCode;
   logic                     prevValid_ff, nxtPrevValid;
   logic                     newCommandFlag_ff, nxtNewCommandFlag;
   logic [15:0]              wordCnt_ff, nxtWordCnt;
   logic [11:0]              pulseEdgeSpacing_ff, nxtPulseEdgeSpacing;
   logic                     refPhase_ff, nxtRefPhase;
   logic [10:0]              shift_ff, nxtShift;
   logic [3:0]               bitsLeft_ff, nxtBitsLeft;
   logic                     pulseOn_ff, nxtPulseOn;
   logic [3:0]               carCnt_ff, nxtCarCnt;
   logic [2:0]               perCnt_ff, nxtPerCnt;
   logic                     irOut_ff;
   logic [LINES-1:0]         drvOe_ff, nxtDrvOe;
   logic [15:0]              wordsSent_ff, nxtWordsSent;
   logic                     ctrlEnable_ff;
   logic                     ack_ff;
   logic [31:0]              rdData_ff, rdMux, statusWord;
   logic                     fire;

   irpd_osc_tick #(
      .DIV     (OSC_DIV)
   ) u_osc_tick (
      .clk     (clk),
      .rst_b   (rst_b),
      .oscTick (oscTick)
   );

   // pins from outside the clock domain pass two flops first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA_ff <= '1;
         syncB_ff <= '1;
      end else begin
         syncA_ff <= {keyDriveLinesIn, keySenseLines, addressModeStrapInput};
         syncB_ff <= syncA_ff;
      end
   end

   // synchronised pin levels and matrix decoding
   wire [LINES-1:0] drvLevel  = syncB_ff[2*LINES:LINES+1];
   wire [LINES-1:0] senseLow  = ~syncB_ff[LINES:1];
   wire             strapLow  = ~syncB_ff[0];
   wire             senseAny  = |senseLow;
   wire             slotLast  = (slot_ff == SLOT_LAST);
   wire [LINES-1:0] lineOneHot = LINES'(1) << scanLine_ff;
   wire [5:0]       lineCode  = {senseIndex(senseLow), scanLine_ff};
   wire             endFound  = scanFound_ff | senseAny;
   wire [5:0]       endCode   = scanFound_ff ? scanCode_ff : lineCode;

   wire [4:0] subsystemAddressBits = decodeStrap(strapMask_ff[5:0]);
   wire       longAddr = subsystemAddressBits[4];
   wire       mode2 = strapMask_ff[6];
   // flip on a new key only
   wire       nextToggle = (!prevValid_ff || endCode != lastCode_ff) ?
                           ~newCommandFlag_ff : newCommandFlag_ff;
   wire [11:0] gapTarget = refPhase_ff ? GAP_REF : (shift_ff[10] ? GAP_ONE : GAP_ZERO);
   wire [15:0] scanAt = longAddr ? SCAN_AT_LONG : SCAN_AT_SHORT;

   // sequencer: standby, matrix scan, word transmission
   always_comb begin
      nxtState            = state_ff;
      nxtScanLine         = scanLine_ff;
      nxtSlot             = slot_ff;
      nxtFirstScan        = firstScan_ff;
      nxtStrapMask        = strapMask_ff;
      nxtScanFound        = scanFound_ff;
      nxtScanCode         = scanCode_ff;
      nxtLastCode         = lastCode_ff;
      nxtPrevValid        = prevValid_ff;
      nxtNewCommandFlag   = newCommandFlag_ff;
      nxtWordCnt          = wordCnt_ff;
      nxtPulseEdgeSpacing = pulseEdgeSpacing_ff;
      nxtRefPhase         = refPhase_ff;
      nxtShift            = shift_ff;
      nxtBitsLeft         = bitsLeft_ff;
      nxtWordsSent        = wordsSent_ff;
      fire                = 1'b0;
      case (state_ff)
         irpd_pkg::ST_STANDBY: begin
            if (oscTick && ctrlEnable_ff && senseAny) begin
               nxtState     = irpd_pkg::ST_SCAN;
               nxtFirstScan = 1'b1;
               nxtStrapMask = '0;
               nxtScanLine  = 3'h0;
               nxtSlot      = 2'h0;
               nxtScanFound = 1'b0;
            end
         end
         irpd_pkg::ST_SCAN: begin
            if (oscTick) begin
               if (slotLast) begin
                  if (firstScan_ff && strapLow) begin
                     nxtStrapMask = strapMask_ff | lineOneHot;
                  end
                  if (!scanFound_ff && senseAny) begin
                     nxtScanFound = 1'b1;
                     nxtScanCode  = lineCode;
                  end
                  if (scanLine_ff == LINE_LAST) begin
                     nxtFirstScan = 1'b0;
                     // only a key starts a word
                     if (endFound && ctrlEnable_ff) begin
                        nxtState            = irpd_pkg::ST_SEND;
                        fire                = 1'b1;
                        nxtWordCnt          = 16'h0000;
                        nxtPulseEdgeSpacing = 12'h000;
                        nxtRefPhase         = 1'b1;
                        nxtNewCommandFlag   = nextToggle;
                        nxtLastCode         = endCode;
                        nxtPrevValid        = 1'b1;
                        nxtWordsSent        = wordsSent_ff + 16'h0001;
                        // top address bit only if long
                        if (longAddr) begin
                           nxtShift    = {nextToggle, subsystemAddressBits[3:0], endCode};
                           nxtBitsLeft = 4'hb;
                        end else begin
                           nxtShift    = {nextToggle, subsystemAddressBits[2:0], endCode, 1'b0};
                           nxtBitsLeft = 4'ha;
                        end
                     end else begin
                        nxtState     = irpd_pkg::ST_STANDBY;
                        nxtPrevValid = 1'b0;
                     end
                  end else begin
                     nxtScanLine = scanLine_ff + 3'h1;
                     nxtSlot     = 2'h0;
                  end
               end else begin
                  nxtSlot = slot_ff + 2'h1;
               end
            end
         end
         irpd_pkg::ST_SEND: begin
            if (oscTick) begin
               nxtWordCnt          = wordCnt_ff + 16'h0001;
               nxtPulseEdgeSpacing = pulseEdgeSpacing_ff + 12'h001;
               if (refPhase_ff && mode2 && pulseEdgeSpacing_ff == GAP_MID) begin
                  fire = 1'b1;
               end
               if ((refPhase_ff || bitsLeft_ff != 4'h0) && pulseEdgeSpacing_ff == gapTarget) begin
                  fire                = 1'b1;
                  nxtPulseEdgeSpacing = 12'h000;
                  if (refPhase_ff) begin
                     nxtRefPhase = 1'b0;
                  end else begin
                     nxtShift    = {shift_ff[9:0], 1'b0};
                     nxtBitsLeft = bitsLeft_ff - 4'h1;
                  end
               end
               if (wordCnt_ff == scanAt) begin
                  nxtState     = irpd_pkg::ST_SCAN;
                  nxtScanLine  = 3'h0;
                  nxtSlot      = 2'h0;
                  nxtScanFound = 1'b0;
               end
            end
         end
         default: begin
            nxtState = irpd_pkg::ST_STANDBY;
         end
      endcase
   end

   always_comb begin
      nxtPulseOn = pulseOn_ff;
      nxtCarCnt  = carCnt_ff;
      nxtPerCnt  = perCnt_ff;
      if (oscTick && pulseOn_ff) begin
         if (carCnt_ff == CAR_LAST) begin
            nxtCarCnt = 4'h0;
            if (perCnt_ff == PER_LAST) begin
               nxtPulseOn = 1'b0;
            end else begin
               nxtPerCnt = perCnt_ff + 3'h1;
            end
         end else begin
            nxtCarCnt = carCnt_ff + 4'h1;
         end
      end
      if (fire) begin
         nxtPulseOn = 1'b1;
         nxtCarCnt  = 4'h0;
         nxtPerCnt  = 3'h0;
      end
   end

   always_comb begin
      if (nxtState == irpd_pkg::ST_STANDBY) begin
         nxtDrvOe = '1;
      end else if (nxtState == irpd_pkg::ST_SCAN) begin
         nxtDrvOe = LINES'(1) << nxtScanLine;
      end else begin
         nxtDrvOe = '0;
      end
   end

   // sequencer registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff            <= irpd_pkg::ST_STANDBY;
         scanLine_ff         <= 3'h0;
         slot_ff             <= 2'h0;
         firstScan_ff        <= 1'b0;
         strapMask_ff        <= '0;
         scanFound_ff        <= 1'b0;
         scanCode_ff         <= 6'h00;
         lastCode_ff         <= 6'h00;
         prevValid_ff        <= 1'b0;
         newCommandFlag_ff   <= 1'b0;
         wordCnt_ff          <= 16'h0000;
         pulseEdgeSpacing_ff <= 12'h000;
         refPhase_ff         <= 1'b0;
         shift_ff            <= 11'h000;
         bitsLeft_ff         <= 4'h0;
         wordsSent_ff        <= 16'h0000;
      end else begin
         state_ff            <= nxtState;
         scanLine_ff         <= nxtScanLine;
         slot_ff             <= nxtSlot;
         firstScan_ff        <= nxtFirstScan;
         strapMask_ff        <= nxtStrapMask;
         scanFound_ff        <= nxtScanFound;
         scanCode_ff         <= nxtScanCode;
         lastCode_ff         <= nxtLastCode;
         prevValid_ff        <= nxtPrevValid;
         newCommandFlag_ff   <= nxtNewCommandFlag;
         wordCnt_ff          <= nxtWordCnt;
         pulseEdgeSpacing_ff <= nxtPulseEdgeSpacing;
         refPhase_ff         <= nxtRefPhase;
         shift_ff            <= nxtShift;
         bitsLeft_ff         <= nxtBitsLeft;
         wordsSent_ff        <= nxtWordsSent;
      end
   end

   // pulse and pin registers; output lags the carrier count by a cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulseOn_ff <= 1'b0;
         carCnt_ff  <= 4'h0;
         perCnt_ff  <= 3'h0;
         irOut_ff   <= 1'b0;
         drvOe_ff   <= '1;
      end else begin
         pulseOn_ff <= nxtPulseOn;
         carCnt_ff  <= nxtCarCnt;
         perCnt_ff  <= nxtPerCnt;
         // high part of each 12-period carrier
         irOut_ff   <= pulseOn_ff && (carCnt_ff < CAR_HIGH);
         drvOe_ff   <= nxtDrvOe;
      end
   end

   assign strapPullDnEn      = (state_ff == irpd_pkg::ST_STANDBY);
   assign strapPullUpEn      = (state_ff != irpd_pkg::ST_STANDBY);
   assign keyDriveLinesOe    = drvOe_ff;
   assign keyDriveLinesOut   = '0;
   assign infraredCodeOutput = irOut_ff;

   // wishbone decode; one wait state, ack drops after one cycle
   wire busReq   = wbReq.cyc && wbReq.stb && !ack_ff;
   wire busWr    = busReq && wbReq.we;
   wire selCtrl  = (wbReq.adr == `IRPD_REG_CTRL);
   wire selStat  = (wbReq.adr == `IRPD_REG_STATUS);
   wire selWords = (wbReq.adr == `IRPD_REG_WORDS);

   // status shows live sequencer state
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`IRPD_STAT_ACTIVE_BIT] = (state_ff != irpd_pkg::ST_STANDBY);
      statusWord[`IRPD_STAT_MODE2_BIT]  = mode2;
      statusWord[`IRPD_STAT_TOGGLE_BIT] = newCommandFlag_ff;
      statusWord[`IRPD_STAT_HELD_BIT]   = prevValid_ff;
      statusWord[`IRPD_STAT_ADDR_LSB +: 5] = subsystemAddressBits;
      statusWord[`IRPD_STAT_CMD_LSB +: 6]  = lastCode_ff;
   end

   // read select; unmapped offsets read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      if (selCtrl) begin
         rdMux[`IRPD_CTRL_ENABLE_BIT] = ctrlEnable_ff;
      end else if (selStat) begin
         rdMux = statusWord;
      end else if (selWords) begin
         rdMux[`IRPD_WORDS_CNT_LSB +: 16]   = wordsSent_ff;
         rdMux[`IRPD_WORDS_DRV_LSB +: LINES] = drvLevel;
      end
   end

   // bus registers; a cleared enable lets the current word finish
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff        <= 1'b0;
         rdData_ff     <= 32'h0000_0000;
         ctrlEnable_ff <= `IRPD_CTRL_RESET;
      end else begin
         ack_ff    <= busReq;
         rdData_ff <= busReq ? rdMux : 32'h0000_0000;
         if (busWr && selCtrl && wbReq.sel[0]) begin
            ctrlEnable_ff <= wbReq.dat[`IRPD_CTRL_ENABLE_BIT];
         end
      end
   end

   // one driver for the whole answer struct
   assign wbRsp = '{ack: ack_ff, dat: rdData_ff};

endmodule : irpd_encoder

// ### testbench/irpd_key_model.sv
`timescale 1ns/1ps
// key matrix switches plus the strap wiring, purely combinational
module irpd_key_model (
   input  wire logic [6:0] lineOe,    // drive lines conducting
   input  wire logic       pullUp,    // strap pull-up on
   input  wire logic       pullDn,    // strap pull-down on
   input  wire logic [6:0] senseSel,  // sense lines the held key touches
   input  wire logic [2:0] drvIdx,    // drive line the held key touches
   input  wire logic [6:0] strapMask, // drive lines wired to the strap pin
   output logic      [6:0] senseLvl,  // sense pin levels
   output logic            strapLvl,  // strap pin level
   output logic      [6:0] drvLvl     // drive pin levels
);
   assign senseLvl = lineOe[drvIdx] ? ~senseSel : 7'h7f;
   assign strapLvl = !pullDn && pullUp && !(|(strapMask & lineOe));
   // released lines float, shown inverted so stale levels never look valid
   assign drvLvl = ~lineOe;
endmodule : irpd_key_model

// ### testbench/irpd_encoder_props.sv
`timescale 1ns/1ps
module irpd_encoder_props #(
   parameter int OSC_DIV = 275, // clocks per resonator period
   parameter int LINES   = 7    // matrix lines
) (
   input wire logic                      clk,                // system clock
   input wire logic                      rst_b,              // async reset
   input wire irpd_pkg::irpd_wb_req_type wbReq,              // bus request
   input wire irpd_pkg::irpd_wb_rsp_type wbRsp,              // bus answer
   input wire logic [LINES-1:0]          keyDriveLinesOe,    // drive enables
   input wire logic                      strapPullUpEn,      // strap pull-up
   input wire logic                      strapPullDnEn,      // strap pull-down
   input wire logic                      infraredCodeOutput  // code output
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [15:0] hiCnt_ff;
   logic [15:0] nxt_hiCnt;
   // length of the current carrier high run
   assign nxt_hiCnt = infraredCodeOutput ? hiCnt_ff + 16'h1 : 16'h0;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) hiCnt_ff <= 16'h0;
      else hiCnt_ff <= nxt_hiCnt;
   end
   a_stby_lines_on: assert property (strapPullDnEn |-> &keyDriveLinesOe)
      else $error("drive lines not all conducting in standby");
   a_pull_exclusive: assert property (strapPullUpEn != strapPullDnEn)
      else $error("strap pull-up and pull-down not exclusive");
   a_stby_ir_quiet: assert property (strapPullDnEn |-> !infraredCodeOutput)
      else $error("code output active in standby");
   a_scan_one_line: assert property (strapPullUpEn |-> $onehot0(keyDriveLinesOe))
      else $error("more than one drive line active while awake");
   a_carrier_high: assert property (
      $fell(infraredCodeOutput) |-> hiCnt_ff == 16'(4 * OSC_DIV))
      else $error("carrier high time wrong");
   a_ack_one_cycle: assert property (wbRsp.ack |=> !wbRsp.ack)
      else $error("ack longer than one cycle");
   a_ack_follows: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
      else $error("ack missing after request");
   a_dat_idle_zero: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
      else $error("read data not zero without ack");
endmodule : irpd_encoder_props

bind irpd_encoder irpd_encoder_props #(.OSC_DIV(OSC_DIV), .LINES(LINES)) u_props (.clk,
   .rst_b, .wbReq, .wbRsp, .keyDriveLinesOe, .strapPullUpEn, .strapPullDnEn,
   .infraredCodeOutput);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int DIV = 2; // short resonator divide keeps the run small
   logic                      clk, rst_b, upEn, dnEn, strapLvl, irOut;
   irpd_pkg::irpd_wb_req_type wbReq;
   irpd_pkg::irpd_wb_rsp_type wbRsp;
   logic [6:0]                oe, drvOut, drvLvl, senseLvl, senseSel, strapMask;
   logic [2:0]                drvIdx;
   logic [31:0]               rd;
   int                        miscompares, tests_run, cyc, lastHi, lastRise, rises, edges[$];
   irpd_encoder #(.OSC_DIV(DIV)) u_dut (.clk, .rst_b, .wbReq, .wbRsp,
      .keyDriveLinesIn(drvLvl), .keyDriveLinesOut(drvOut), .keyDriveLinesOe(oe),
      .keySenseLines(senseLvl), .addressModeStrapInput(strapLvl),
      .strapPullUpEn(upEn), .strapPullDnEn(dnEn), .infraredCodeOutput(irOut));
   irpd_key_model u_keys (.lineOe(oe), .pullUp(upEn), .pullDn(dnEn), .senseSel,
      .drvIdx, .strapMask, .senseLvl, .strapLvl, .drvLvl);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // pulse leading edges are rises after a long quiet; carriers counted per pulse
   always @(posedge clk) begin
      cyc++;
      if (irOut === 1'b1 && cyc - lastHi > 20 * DIV) begin
         if (edges.size() > 0) check("carriers", 32'(rises), 32'h6);
         edges.push_back(cyc);
         rises = 0;
      end
      if (irOut === 1'b1 && lastHi != cyc - 1) begin
         if (rises > 0) check("carrier period", 32'(cyc - lastRise), 32'(12 * DIV));
         rises++;
         lastRise = cyc;
      end
      if (irOut === 1'b1) lastHi = cyc;
      // hang limit, well above the length of all three scenarios
      if (cyc > 90000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      do @(posedge clk); while (wbRsp.ack !== 1'b1);
      rd = wbRsp.dat;
      wbReq <= '0;
   endtask : wb
   // spacing of successive leading edges, in resonator periods
   task automatic gaps(input string what, input int t[$]);
      while (edges.size() <= t.size()) @(posedge clk);
      foreach (t[i]) check(what, 32'(edges[i+1] - edges[i]), 32'(t[i] * DIV));
   endtask : gaps
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      wbReq = '0;
      rst_b = 1'b0;
      senseSel = 7'h0;
      drvIdx = 3'd0;
      strapMask = 7'h0;
      cyc = 0;
      lastHi = -1000;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      check("drive level", 32'(drvOut), 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      check("ctrl reset", rd, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      // a strap change alone, and a key while disabled, must both stay quiet
      strapMask <= 7'h02;
      repeat (400) @(posedge clk);
      check("strap only", 32'(edges.size()), 32'h0);
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      check("ctrl off", rd, 32'h0);
      senseSel <= 7'h04;
      drvIdx <= 3'h1;
      repeat (400) @(posedge clk);
      check("key disabled", 32'(edges.size()), 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      check("words idle", rd, 32'h0);
      $display("quiet test done");
      wb(1'b1, 8'h00, 32'h1);
      while (edges.size() == 0) @(posedge clk);
      // strap moved while the key is held; the latched address must stay
      strapMask <= 7'h04;
      wb(1'b0, 8'h04, 32'h0);
      check("status m1", rd & 32'h003f01f7, 32'h00110015);
      wb(1'b0, 8'h08, 32'h0);
      check("words m1", rd, 32'h007f0001);
      gaps("word m1", {3456, 3456, 2304, 2304, 3456, 2304,
                       3456, 2304, 2304, 2304, 3456});
      $display("mode 1 word done");
      senseSel <= 7'h0;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      edges.delete();
      // drive 6 strap selects the split start pattern
      strapMask <= 7'h40;
      senseSel <= 7'h60;
      drvIdx <= 3'h3;
      while (edges.size() == 0) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      check("status m2", rd & 32'h003f01f7, 32'h003b0077);
      gaps("start m2", {1728, 1728});
      $display("mode 2 start done");
      wrap_up();
   end
endmodule : tb_top
